/* File: mrc_pkg.sv */
/*
 * Package for the multiphase regulator configuration and control block.
 * Holds strap encodings, timing counts, mode enumerations and the packed
 * carriers shared by the top module and the phase generator helper.
 * Assumes a 100 MHz system clock.
 */
`default_nettype none

package mrc_pkg;

  // System clock period in ns
  localparam int CLK_PERIOD_NS = 10;

  // Per-phase free-running switching frequency, in kHz
  localparam int SW_FREQ_KHZ = 200;
  // Cycles in one switching period at the system clock
  localparam int SW_PERIOD_CYC = 1000000 / (SW_FREQ_KHZ * CLK_PERIOD_NS);
  // Width of the period counter
  localparam int PER_W = 12;

  // Tail of the code transition flag after a change settles, in cycles
  localparam logic [5:0] CODE_TRANSITION_FLAG_TAIL_CYC = 6'h20;

  // Fixed soft-start length in table-B mode, in switching periods;
  // kept short so that a full start-up fits a short run
  localparam logic [11:0] SS_FIXED_PER = 12'h004;

  // Table-A regulation offset, in microvolts (subtracted)
  localparam int TABLE_A_OFFSET_UV = 19000;
  // Table-A over-voltage margin above the code, in millivolts
  localparam int OV_MARGIN_A_MV = 175;
  // Table-B fixed over-voltage trip, in millivolts
  localparam int OV_FIXED_B_MV = 1800;
  // Table-A older table extension, in microvolts
  localparam int TABLE_A_EXT_UV = 6250;

  // Transient boost gain ceiling
  localparam logic [1:0] BOOST_GAIN_MAX = 2'h2;

  // Code widths
  localparam int CODE_W = 8;
  localparam int CODE_B_W = 6;

  // Number of phases of the power stage
  localparam int NPH = 3;

  // Decoded table mode
  typedef enum logic {MRC_TABLE_B, MRC_TABLE_A} mrc_table_t;

  // Table variant within table-A mode
  typedef enum logic {MRC_VAR_OLD, MRC_VAR_NEW} mrc_var_t;

  // Decoded configuration held from reset release
  typedef struct packed {
    logic three_phase;     // All three phases in use
    mrc_table_t table_mode;  // Table-A or table-B
    mrc_var_t variant;     // Table-A variant
  } mrc_cfg_t;

  // Per-phase drive commands to the power stage
  typedef struct packed {
    logic [NPH-1:0] hs_on;   // High-side turn-on request
    logic [NPH-1:0] ls_en;   // Low-side enable
  } mrc_drive_t;

  // Status outputs to the processor
  typedef struct packed {
    logic startup_done;       // Startup-done or power-good
    logic code_transition;    // Dynamic code change flag
    logic fault;              // Latched fault
    logic therm_warn;         // Thermal warning
    logic therm_alarm;        // Thermal alarm
  } mrc_status_t;

endpackage : mrc_pkg

`default_nettype wire

/* File: mrc_phase_gen.sv */
/*
 * Interleaved phase clock generator. Produces one period-start pulse per
 * active phase, spread evenly over the switching period.
 * Assumes a same-domain clock enable and a static phase-count choice.
 */
`default_nettype none

module mrc_phase_gen (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Configuration
  input wire logic three_phase_i,
  // Per-phase start pulses
  output logic [mrc_pkg::NPH-1:0] phase_start_o
);
  import mrc_pkg::*;

  localparam logic [PER_W-1:0] PER_LAST = PER_W'(SW_PERIOD_CYC - 1);
  localparam logic [PER_W-1:0] THIRD = PER_W'(SW_PERIOD_CYC / 3);
  localparam logic [PER_W-1:0] HALF = PER_W'(SW_PERIOD_CYC / 2);

  logic [PER_W-1:0] cnt;  // Position within the switching period
  logic [PER_W-1:0] off [NPH];  // Start offset for each phase

  // Period counter at the free-running switching rate
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
    end else if (clk_en_i) begin
      cnt <= (cnt == PER_LAST) ? '0 : cnt + 1'b1;
    end
  end

  // Offsets: 120 degrees apart for three, 180 for phases one and three
  always_comb begin
    off[0] = '0;
    off[1] = THIRD;
    off[2] = three_phase_i ? PER_W'(2 * THIRD) : HALF;
  end

  // One pulse per phase; phase two is idle in two-phase mode
  for (genvar p = 0; p < NPH; p++) begin : g_ph
    always_comb begin
      phase_start_o[p] = clk_en_i && (cnt == off[p])
                         && (p != 1 || three_phase_i);
    end
  end

endmodule : mrc_phase_gen

`default_nettype wire

/* File: mrc_sync.sv */
/*
 * Two-flop synchroniser bank for pin inputs.
 * Assumes inputs arrive asynchronous to sys_clk_i.
 */
`default_nettype none

module mrc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Raw and synchronised levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;  // First stage, read only by the second

  // Two flip-flops before any logic looks at a pin
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= '0;
      q_o <= '0;
    end else if (clk_en_i) begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : mrc_sync

`default_nettype wire

/* File: mrc_top.sv */
/*
 * Configuration, sequencing and protection control of a two/three phase
 * step-down regulator controller. Analog comparators outside this block
 * deliver their results as pin-level inputs; the power stage takes the
 * per-phase drive commands.
 */
`default_nettype none

module mrc_top (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Strap pins (1 = floating / resistor present)
  input wire logic phase_count_strap_i,
  input wire logic table_mode_strap_i,
  input wire logic table_variant_select_i,
  input wire logic [1:0] mode_resistor_code_i,
  // Processor voltage code pins, as seen at the pin
  input wire logic [mrc_pkg::CODE_W-1:0] voltage_code_inputs_i,
  // Analog comparator results
  input wire logic supply_ok_i,
  input wire logic ov_trip_i,
  input wire logic prelim_ov_i,
  input wire logic oc_trip_i,
  input wire logic load_step_i,
  input wire logic boost_enable_i,
  input wire logic in_regulation_i,
  input wire logic [1:0] thermal_level_i,
  input wire logic [mrc_pkg::NPH-1:0] pwm_i,
  // Configuration seen by the analog core
  output mrc_pkg::mrc_cfg_t cfg_o,
  output logic [mrc_pkg::CODE_W-1:0] ref_tap_o,
  output logic ref_offset_en_o,
  output logic [1:0] boost_gain_o,
  // Power stage drive and status to the processor
  output mrc_pkg::mrc_drive_t drive_o,
  output mrc_pkg::mrc_status_t status_o
);
  import mrc_pkg::*;

  typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN} mrc_seq_t;

  localparam int NSYNC = 10 + CODE_W;

  logic [NSYNC-1:0] raw;      // Pins before synchronising
  logic [NSYNC-1:0] syn;      // Pins after two flops
  logic [CODE_W-1:0] code_pin; // Synchronised code pins
  logic cfg_taken;            // Straps already captured
  logic [1:0] ss_sel;         // Soft-start choice from the resistor
  mrc_seq_t state;            // Start-up sequence state
  mrc_seq_t next_state;
  logic [11:0] ss_cnt;        // Soft-start period counter
  logic [11:0] ss_len;        // Soft-start length in periods
  logic ov_latch;             // Over-voltage latch
  logic oc_latch;             // Over-current latch
  logic [CODE_W-1:0] code_q;  // Decoded code last cycle
  logic [CODE_W-1:0] code_dec;  // Decoded code this cycle
  logic [5:0] tail_cnt;       // Transition flag tail counter
  logic [NPH-1:0] ph_start;   // Interleaved period starts
  logic [NPH-1:0] active_ph;  // Phases in use
  logic boost_now;            // Boost firing this cycle

  // Pins from outside, except supply_ok_i, boost_enable_i and the straps, cross into the clock domain first
  assign raw = {voltage_code_inputs_i, pwm_i, thermal_level_i,
                in_regulation_i, load_step_i, oc_trip_i, ov_trip_i,
                prelim_ov_i};

  mrc_sync #(.W(NSYNC)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .d_i(raw),
    .q_o(syn)
  );

  assign code_pin = syn[NSYNC-1 -: CODE_W];

  // Strap capture on the first enabled edge after reset release
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_taken <= 1'b0;
      cfg_o <= '0;
      ss_sel <= '0;
      boost_gain_o <= BOOST_GAIN_MAX;
    end else if (clk_en_i && !cfg_taken) begin
      cfg_taken <= 1'b1;
      cfg_o.three_phase <= !phase_count_strap_i;
      cfg_o.table_mode <= table_mode_strap_i ? MRC_TABLE_A
                                             : MRC_TABLE_B;
      // Variant is only meaningful in table-A; frozen for good
      cfg_o.variant <= (table_mode_strap_i && table_variant_select_i)
                       ? MRC_VAR_NEW : MRC_VAR_OLD;
      ss_sel <= table_mode_strap_i ? mode_resistor_code_i : 2'h0;
      // Gain from the resistor, capped; table-B fixed at the cap
      if (table_mode_strap_i && mode_resistor_code_i < BOOST_GAIN_MAX)
      begin
        boost_gain_o <= mode_resistor_code_i;
      end else begin
        boost_gain_o <= BOOST_GAIN_MAX;
      end
    end
  end

  // Offset applies in table-A only
  assign ref_offset_en_o = (cfg_o.table_mode == MRC_TABLE_A);

  // Soft-start length: resistor-chosen in table-A, fixed in table-B
  always_comb begin
    ss_len = SS_FIXED_PER;
    if (cfg_o.table_mode == MRC_TABLE_A) begin
      ss_len = SS_FIXED_PER << ss_sel;
    end
  end

  // Code decode: table-A reads pins as is (open pins read one);
  // table-B keeps six bits (open pins read zero), upper bits masked
  always_comb begin
    if (cfg_o.table_mode == MRC_TABLE_A) begin
      code_dec = code_pin;
    end else begin
      code_dec = {2'h0, code_pin[CODE_B_W-1:0]};
    end
  end

  // Registered code selects the reference divider tap
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_q <= '0;
      ref_tap_o <= '0;
    end else if (clk_en_i) begin
      code_q <= code_dec;
      ref_tap_o <= code_dec;
    end
  end

  // Transition flag, table-B only: high while the code moves, then 32 more cycles
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tail_cnt <= '0;
      status_o.code_transition <= 1'b0;
    end else if (clk_en_i) begin
      if (cfg_o.table_mode != MRC_TABLE_B || !cfg_taken) begin
        tail_cnt <= '0;
        status_o.code_transition <= 1'b0;
      end else if (code_dec != code_q) begin
        tail_cnt <= CODE_TRANSITION_FLAG_TAIL_CYC;
        status_o.code_transition <= 1'b1;
      end else if (tail_cnt != 6'h0) begin
        tail_cnt <= tail_cnt - 6'h1;
        status_o.code_transition <= 1'b1;
      end else begin
        status_o.code_transition <= 1'b0;
      end
    end
  end

  mrc_phase_gen u_phase (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .three_phase_i(cfg_o.three_phase),
    .phase_start_o(ph_start)
  );

  // Sequencer: off, soft-start, running
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: if (supply_ok_i && cfg_taken && !ov_latch && !oc_latch)
        next_state = ST_SOFT;
      ST_SOFT: if (ss_cnt >= ss_len) next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_OFF;
    endcase
    if (!supply_ok_i || ov_latch || oc_latch) begin
      next_state = ST_OFF;
    end
  end

  // Sequence state and soft-start counting per switching period
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_OFF;
      ss_cnt <= '0;
    end else if (clk_en_i) begin
      state <= next_state;
      if (state != ST_SOFT) begin
        ss_cnt <= '0;
      end else if (ph_start[0]) begin
        ss_cnt <= ss_cnt + 12'h1;
      end
    end
  end

  // Protection latches, cleared only by reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ov_latch <= 1'b0;
      oc_latch <= 1'b0;
    end else if (clk_en_i) begin
      if (syn[1] || (!supply_ok_i && syn[0])) begin
        ov_latch <= 1'b1;
      end
      if (syn[2] && state != ST_OFF) begin
        oc_latch <= 1'b1;
      end
    end
  end

  // Start-up done / power-good and the other status outputs
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_o.startup_done <= 1'b0;
      status_o.fault <= 1'b0;
      status_o.therm_warn <= 1'b0;
      status_o.therm_alarm <= 1'b0;
    end else if (clk_en_i) begin
      if (cfg_o.table_mode == MRC_TABLE_A) begin
        status_o.startup_done <= (state == ST_RUN);
      end else begin
        status_o.startup_done <= (state == ST_RUN) && syn[4];
      end
      status_o.fault <= ov_latch || oc_latch;
      status_o.therm_warn <= syn[5];
      status_o.therm_alarm <= syn[6];
    end
  end

  assign active_ph = cfg_o.three_phase ? 3'b111 : 3'b101;
  // Boost only with the feature on and a load step seen while running
  assign boost_now = boost_enable_i && syn[3] && state == ST_RUN;

  // Power stage commands, priority: over-current, over-voltage, normal
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_o <= '0;
    end else if (clk_en_i) begin
      if (oc_latch) begin
        drive_o <= '0;
      end else if (ov_latch) begin
        drive_o.hs_on <= '0;
        drive_o.ls_en <= active_ph;
      end else if (state == ST_OFF) begin
        drive_o <= '0;
      end else begin
        if (boost_now) begin
          drive_o.hs_on <= active_ph;
        end else begin
          drive_o.hs_on <= syn[9:7] & active_ph;
        end
        drive_o.ls_en <= (state == ST_SOFT) ? '0 : active_ph;
      end
    end
  end

  // Checks
  a_oc_kills_drive: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) oc_latch && clk_en_i |=> drive_o == '0)
    else $error("drive active after over-current");
  a_ov_low_side: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) ov_latch && !oc_latch && clk_en_i
    |=> drive_o.ls_en == active_ph && status_o.fault)
    else $error("over-voltage response missing");
  a_soft_no_ls: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) state == ST_SOFT |-> drive_o.ls_en == '0)
    else $error("low side on in soft-start");
  a_two_phase_idle: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) !cfg_o.three_phase |-> !drive_o.hs_on[1]
    && !drive_o.ls_en[1])
    else $error("phase two used in two-phase mode");
  a_cfg_static: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) cfg_taken |=> $stable(cfg_o))
    else $error("configuration changed");
  a_tail_holds: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) clk_en_i && cfg_o.table_mode == MRC_TABLE_B
    && cfg_taken && code_dec != code_q |=> status_o.code_transition[*8])
    else $error("transition flag dropped early");
  a_pg_reg: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) status_o.startup_done
    && cfg_o.table_mode == MRC_TABLE_B |-> $past(syn[4]))
    else $error("power-good without regulation");
  a_boost_gain: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) boost_gain_o <= BOOST_GAIN_MAX
    && (cfg_o.table_mode == MRC_TABLE_A || boost_gain_o == 2'h2))
    else $error("boost gain out of range");
  a_offset_mode: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i) ref_offset_en_o
    == (cfg_o.table_mode == MRC_TABLE_A))
    else $error("offset enable wrong for table");

endmodule : mrc_top

`default_nettype wire

/* File: mrc_cpu_model.sv */
/*
 * Processor-side model: drives the voltage code pins after a programmable
 * delay, so that both prompt and slow code updates can be produced.
 * Assumes the bench changes its requests on the falling clock edge.
 */
`default_nettype none

module mrc_cpu_model (
  // Clock
  input wire logic sys_clk_i,
  // Request from the bench
  input wire logic table_a_i,
  input wire logic [7:0] code_i,
  input wire logic [3:0] delay_i,
  // Pin levels seen by the block
  output logic [7:0] voltage_code_inputs_o
);
  // Pending code and its remaining delay
  logic [7:0] pend = 8'h00;
  logic [3:0] cnt = 4'h0;

  initial voltage_code_inputs_o = 8'h00;

  // Apply a new code once its delay has run out, off the sampling edge
  always @(negedge sys_clk_i) begin
    if (code_i !== pend) begin
      pend <= code_i;
      cnt <= delay_i;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (table_a_i) begin
      voltage_code_inputs_o <= pend;
    end else begin
      // Unused upper inputs sit grounded in table-B mode
      voltage_code_inputs_o <= {2'b00, pend[5:0]};
    end
  end
endmodule : mrc_cpu_model

`default_nettype wire

/* File: mrc_top_tb.sv */
/*
 * Self-checking bench for the regulator control block: strap decode,
 * code path and transition flag, protections, boost and start-up status.
 * Assumes the latencies given for the block: three edges from pin to
 * registered outputs, four through the protection latches.
 */
`default_nettype none

module mrc_top_tb;
  import mrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus and observation
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ph = 1'b1, tm = 1'b1, vs = 1'b1;
  logic [1:0] rsel = 2'h0, therm = 2'h0;
  logic sup = 1'b0, ov = 1'b0, pov = 1'b0, oc = 1'b0, ls = 1'b0;
  logic ben = 1'b0, reg_ok = 1'b0;
  logic [2:0] pwm = 3'h0;
  logic [7:0] code = 8'h00, pins;
  logic [3:0] dly = 4'h0;
  logic en = 1'b1;
  mrc_cfg_t cfg;
  logic [7:0] tap;
  logic off_en;
  logic [1:0] gain;
  mrc_drive_t drv;
  mrc_status_t st;
  int error_cnt = 0;
  int n_checks = 0;

  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;

  mrc_cpu_model u_cpu (.sys_clk_i(sys_clk_i), .table_a_i(tm), .code_i(code),
    .delay_i(dly), .voltage_code_inputs_o(pins));

  mrc_top u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(en),
    .phase_count_strap_i(ph), .table_mode_strap_i(tm),
    .table_variant_select_i(vs), .mode_resistor_code_i(rsel),
    .voltage_code_inputs_i(pins), .supply_ok_i(sup), .ov_trip_i(ov),
    .prelim_ov_i(pov), .oc_trip_i(oc), .load_step_i(ls),
    .boost_enable_i(ben), .in_regulation_i(reg_ok),
    .thermal_level_i(therm), .pwm_i(pwm), .cfg_o(cfg), .ref_tap_o(tap),
    .ref_offset_en_o(off_en), .boost_gain_o(gain), .drive_o(drv),
    .status_o(st));

  // Compare one value against its expectation
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask : chk

  // Let n falling edges pass
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cyc

  // Reset with straps settled before start-up, all comparator inputs quiet
  task automatic boot(input logic p, input logic t);
    cyc(1);
    {sup, ov, pov, oc, ls, ben, reg_ok, pwm, therm} = '0;
    ph = p;
    tm = t;
    rst_b_i = 1'b0;
    cyc(5);
    rst_b_i = 1'b1;
    cyc(3);
  endtask : boot

  // Strap decode, offset, gain, and straps frozen after capture
  task automatic t_cfg();
    for (int i = 0; i < 4; i++) begin
      rsel = i[1] ? 2'h1 : 2'h3;
      boot(i[0], i[1]);
      chk(cfg.three_phase, !i[0], "phases");
      chk(cfg.table_mode, i[1], "table");
      chk(cfg.variant, i[1], "variant");
      chk(off_en, i[1], "offset");
      chk(gain <= 2'h2, 1'b1, "gain cap");
      chk(gain, i[1] ? 2'h1 : 2'h2, "gain");
      ph = !ph;
      tm = !tm;
      cyc(5);
      chk(cfg.three_phase, !i[0], "phases held");
      chk(cfg.table_mode, i[1], "table held");
    end
    $display("test cfg done");
  endtask : t_cfg

  // Code path in both modes, transition flag tail in table-B
  task automatic t_code();
    for (int t = 0; t < 2; t++) begin
      boot(1'b0, t[0]);
      therm = 2'h3;
      dly = t[0] ? 4'h4 : 4'h0;
      code = t[0] ? 8'hc5 : 8'hff;
      cyc(12);
      chk(tap, t[0] ? 8'hc5 : 8'h3f, "tap");
      chk(st.therm_warn, 1'b1, "warn");
      chk(st.therm_alarm, 1'b1, "alarm");
      if (!t[0]) begin
        chk(st.code_transition, 1'b1, "flag up");
        cyc(24);
        chk(st.code_transition, 1'b1, "flag tail");
        cyc(10);
        chk(st.code_transition, 1'b0, "flag down");
      end
    end
    code = 8'h00;
    $display("test code done");
  endtask : t_code

  // Over-voltage, preliminary over-voltage and over-current latches
  task automatic t_prot();
    boot(1'b0, 1'b1);
    en = 1'b0;
    sup = 1'b1;
    ov = 1'b1;
    cyc(6);
    chk(st.fault, 1'b0, "frozen");
    en = 1'b1;
    cyc(6);
    ov = 1'b0;
    cyc(6);
    chk(st.fault, 1'b1, "ov fault");
    chk(drv.ls_en, 3'h7, "ov low sides");
    boot(1'b0, 1'b0);
    pov = 1'b1;
    cyc(6);
    chk(st.fault, 1'b1, "early ov");
    boot(1'b0, 1'b1);
    sup = 1'b1;
    pwm = 3'h7;
    cyc(10);
    oc = 1'b1;
    cyc(6);
    oc = 1'b0;
    cyc(6);
    chk(drv, 6'h00, "oc off");
    chk(st.fault, 1'b1, "oc fault");
    $display("test prot done");
  endtask : t_prot

  // Soft-start status and low sides, then boost on and off
  task automatic t_run();
    for (int p = 0; p < 3; p++) begin
      rsel = 2'h0;
      boot(p[0], p == 2);
      sup = 1'b1;
      reg_ok = (p != 2);
      cyc(50);
      chk(st.startup_done, 1'b0, "done early");
      chk(drv.ls_en, 3'h0, "low sides");
      // Bounded wait for the end of soft-start
      for (int k = 0; k < 3000 && st.startup_done !== 1'b1; k++) cyc(1);
      chk(st.startup_done, 1'b1, "done");
      cyc(2);
      chk(drv.ls_en, p[0] ? 3'h5 : 3'h7, "low sides run");
      if (p != 2) begin
        reg_ok = 1'b0;
        cyc(6);
        chk(st.startup_done, 1'b0, "out of regulation");
      end
      ben = 1'b1;
      ls = 1'b1;
      cyc(6);
      chk(drv.hs_on, p[0] ? 3'h5 : 3'h7, "boost");
      ben = 1'b0;
      pwm = 3'h2;
      cyc(6);
      chk(drv.hs_on, p[0] ? 3'h0 : 3'h2, "no boost");
    end
    $display("test run done");
  endtask : t_run

  // Final counts and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Hang guard
  initial begin
    #1ms;
    error_cnt++;
    $display("unexpected %0t run limit reached", $time);
    test_done();
  end

  // Main sequence
  initial begin
    cyc(5);
    rst_b_i = 1'b1;
    t_cfg();
    t_code();
    t_prot();
    t_run();
    test_done();
  end
endmodule : mrc_top_tb

`default_nettype wire
